/* File: spr_pkg.sv */
package spr_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SHOW_MS = 2000;  // setpoint display hold after release
  localparam int SLOW_MS = 500;   // slow scroll step period
  localparam int FAST_MS = 100;   // fast scroll step period
  localparam int SHOW_CYC = CLK_HZ / 1000 * SHOW_MS;
  localparam int SLOW_CYC = CLK_HZ / 1000 * SLOW_MS;
  localparam int FAST_CYC = CLK_HZ / 1000 * FAST_MS;
  localparam int CNT_W = 25;

  // ----------------------------------------------------------------
  // channels, setpoint and display encoding
  // ----------------------------------------------------------------
  localparam int NCH = 6;
  localparam int NLINE = 3;
  localparam int LINE_W = 14;  // {overflow, exponent[4:0], digit_hi, digit_lo}
  localparam int PIN_W = NLINE * LINE_W + 7;
  localparam logic [3:0] MANT_ZERO = 4'h0;
  localparam logic [3:0] MANT_ONE = 4'h1;
  localparam logic [3:0] MANT_MAX = 4'h9;
  localparam logic [3:0] MANT_ATM = 4'hF;  // above-atmosphere setpoint code
  localparam logic signed [4:0] EXP_MIN = -5'sd12;
  localparam logic signed [4:0] EXP_MAX = 5'sd5;

  // ----------------------------------------------------------------
  // register map (byte offsets) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_POL = 8'h00;
  localparam logic [7:0] ADDR_ASN = 8'h04;
  localparam logic [7:0] ADDR_OVR = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_SP0 = 8'h10;
  localparam logic [7:0] ADDR_SP5 = 8'h24;
  localparam logic [5:0] POL_RST = 6'h00;    // activation below setpoint
  localparam logic [3:0] ASN_RST = 4'h0;     // both ion gauges may drive
  localparam logic [11:0] OVR_RST = 12'h000; // all automatic
  localparam logic [1:0] OVR_AUTO = 2'h0;
  localparam logic [1:0] OVR_OFF = 2'h1;
  localparam logic [1:0] OVR_ON = 2'h2;
  localparam int STAT_ION1 = 6;
  localparam int STAT_ION2 = 7;
  localparam int STAT_SHOW = 8;
  localparam int STAT_SEL = 9;

  // ----------------------------------------------------------------
  // setpoint button handling states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_HELD = 3'h2,
    ST_SHOW = 3'h4
  } spr_ui_t;

endpackage : spr_pkg

/* File: spr_cmp_chan.sv */
`timescale 1ns/1ps

module spr_cmp_chan (
  input wire logic clk,                 // system clock
  input wire logic rst_n,               // async reset, active low
  input wire logic upd,                 // fresh pressure data may be used
  input wire logic [6:0] p_val,         // displayed two-digit mantissa 10..99
  input wire logic signed [4:0] p_exp,  // displayed exponent
  input wire logic p_ovf,               // display shows overflow
  input wire logic [3:0] sp_mant,       // setpoint mantissa or special code
  input wire logic signed [4:0] sp_exp, // setpoint exponent
  output logic below_q                  // pressure below setpoint, hysteretic
);

  // ----------------------------------------------------------------
  // thresholds: activate under sp, release at sp plus ten percent
  // ----------------------------------------------------------------
  logic [6:0] lo_val;
  logic [6:0] hi_val;
  logic exp_eq;
  logic lt_lo;
  logic ge_hi;
  logic below_d;

  assign lo_val = 7'(sp_mant) * 7'h0A;
  assign hi_val = lo_val + 7'(sp_mant);
  assign exp_eq = (p_exp == sp_exp);
  // exponent decides first, mantissa only within one decade
  assign lt_lo = (p_exp < sp_exp) || (exp_eq && (p_val < lo_val));
  assign ge_hi = (p_exp > sp_exp) || (exp_eq && (p_val >= hi_val));

  // next state: special setpoint codes before numeric compare
  always_comb begin
    below_d = below_q;
    if (sp_mant == spr_pkg::MANT_ZERO) begin
      below_d = 1'b0;
    end else if (sp_mant == spr_pkg::MANT_ATM) begin
      below_d = ~p_ovf;
    end else if (p_ovf) begin
      below_d = 1'b0;
    end else if (lt_lo) begin
      below_d = 1'b1;
    end else if (ge_hi) begin
      below_d = 1'b0;
    end
  end

  // state only moves on live (unfrozen) display data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      below_q <= 1'b0;
    end else if (upd) begin
      below_q <= below_d;
    end
  end

endmodule : spr_cmp_chan

/* File: spr_relay_ctrl.sv */
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// - setpoint kept as mantissa digit plus exponent
// - compare against display data, no unit conversion
// - above-atmosphere setpoint active except on overflow
// - zero setpoint deactivates relay at polarity off, activates at polarity on
// - channels 1-2 ion, 3-4 gauge A, 5-6 B
// - channels 1 and 2 assignable to ion gauges
// - every channel has selectable polarity
// - indicators show actual relay state
// - button press shows selected setpoint on line
// - held button steps setpoint up or down
// - slow stepping, fast after decade crossing
// - two seconds after release, revert and store
// - relay from comparison or manual override
// - ten percent hysteresis on each setpoint
// - three-position override: on, off, automatic
// - polarity off activates below, on above
// - both ion gauges off releases relays 1-2
module spr_relay_ctrl #(
  parameter int SHOW_CYC = spr_pkg::SHOW_CYC,  // setpoint display hold
  parameter int SLOW_CYC = spr_pkg::SLOW_CYC,  // slow step period
  parameter int FAST_CYC = spr_pkg::FAST_CYC   // fast step period
) (
  input wire logic clk,                    // 10 MHz system clock
  input wire logic rst_n,                  // async reset, active low
  input wire logic [7:0] paddr,            // apb address
  input wire logic psel,                   // apb select
  input wire logic penable,                // apb enable
  input wire logic pwrite,                 // apb write
  input wire logic [31:0] pwdata,          // apb write data
  output logic [31:0] prdata,              // apb read data
  output logic pready,                     // apb ready
  output logic pslverr,                    // apb error on unmapped address
  input wire logic [3:0] line1_digit_hi,   // display line 1 first digit
  input wire logic [3:0] line1_digit_lo,   // display line 1 second digit
  input wire logic [4:0] line1_exp,        // display line 1 exponent
  input wire logic line1_ovf,              // display line 1 overflow
  input wire logic [3:0] line2_digit_hi,   // display line 2 first digit
  input wire logic [3:0] line2_digit_lo,   // display line 2 second digit
  input wire logic [4:0] line2_exp,        // display line 2 exponent
  input wire logic line2_ovf,              // display line 2 overflow
  input wire logic [3:0] line3_digit_hi,   // display line 3 first digit
  input wire logic [3:0] line3_digit_lo,   // display line 3 second digit
  input wire logic [4:0] line3_exp,        // display line 3 exponent
  input wire logic line3_ovf,              // display line 3 overflow
  input wire logic ion_gauge_one_on,       // first ion gauge running
  input wire logic ion_gauge_two_on,       // second ion gauge running
  input wire logic btn_up,                 // setpoint up button, high pressed
  input wire logic btn_down,               // setpoint down button, high pressed
  input wire logic [2:0] thumbwheel,       // channel select 1..6
  output logic [5:0] relay,                // relay drive, bit 0 is channel one
  output logic [5:0] relay_led,            // relay status indicators
  output logic [2:0] sp_show_line,         // one-hot line taken by setpoint
  output logic [3:0] sp_show_mant,         // setpoint mantissa shown
  output logic [4:0] sp_show_exp,          // setpoint exponent shown
  output logic nv_wr_stb,                  // store pulse to non-volatile memory
  output logic [2:0] nv_wr_chan,           // channel stored, 0 based
  output logic [3:0] nv_wr_mant,           // mantissa stored
  output logic [4:0] nv_wr_exp             // exponent stored
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // setpoint register index from a bus address
  function automatic logic [2:0] sp_index(input logic [7:0] a);
    logic [7:0] off;
    off = a - spr_pkg::ADDR_SP0;
    return off[4:2];
  endfunction : sp_index

  // one scroll step: returns {decade crossed, mantissa, exponent}
  function automatic logic [9:0] step_sp(input logic up, input logic [3:0] m,
                                         input logic signed [4:0] e);
    logic [3:0] nm;
    logic signed [4:0] ne;
    logic cr;
    nm = m;
    ne = e;
    cr = 1'b0;
    if (up) begin
      if (m == spr_pkg::MANT_ZERO) begin
        nm = spr_pkg::MANT_ONE;
        ne = spr_pkg::EXP_MIN;
      end else if (m == spr_pkg::MANT_ATM) begin
        nm = m;
      end else if (m < spr_pkg::MANT_MAX) begin
        nm = m + 4'h1;
      end else if (e == spr_pkg::EXP_MAX) begin
        nm = spr_pkg::MANT_ATM;
      end else begin
        nm = spr_pkg::MANT_ONE;
        ne = e + 5'sd1;
        cr = 1'b1;
      end
    end else begin
      if (m == spr_pkg::MANT_ZERO) begin
        nm = m;
      end else if (m == spr_pkg::MANT_ATM) begin
        nm = spr_pkg::MANT_MAX;
        ne = spr_pkg::EXP_MAX;
      end else if (m > spr_pkg::MANT_ONE) begin
        nm = m - 4'h1;
      end else if (e == spr_pkg::EXP_MIN) begin
        nm = spr_pkg::MANT_ZERO;
      end else begin
        nm = spr_pkg::MANT_MAX;
        ne = e - 5'sd1;
        cr = 1'b1;
      end
    end
    return {cr, nm, ne};
  endfunction : step_sp

  // ----------------------------------------------------------------
  // pin synchroniser: three stages, change taken when 2 and 3 agree
  // ----------------------------------------------------------------
  logic [spr_pkg::PIN_W-1:0] pin_raw;
  logic [spr_pkg::PIN_W-1:0] s1_q;
  logic [spr_pkg::PIN_W-1:0] s2_q;
  logic [spr_pkg::PIN_W-1:0] s3_q;
  logic [spr_pkg::PIN_W-1:0] flt_q;
  logic [spr_pkg::PIN_W-1:0] flt_d;

  assign pin_raw = {thumbwheel, btn_down, btn_up, ion_gauge_two_on, ion_gauge_one_on,
                    line3_ovf, line3_exp, line3_digit_hi, line3_digit_lo,
                    line2_ovf, line2_exp, line2_digit_hi, line2_digit_lo,
                    line1_ovf, line1_exp, line1_digit_hi, line1_digit_lo};
  assign flt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & flt_q);

  // synchroniser and agreement filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      flt_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end

  // ----------------------------------------------------------------
  // filtered operator and gauge signals
  // ----------------------------------------------------------------
  localparam int PB = spr_pkg::NLINE * spr_pkg::LINE_W;
  logic ion1;
  logic ion2;
  logic up_s;
  logic dn_s;
  logic [2:0] thumb_s;
  logic [6:0] ln_val [spr_pkg::NLINE];
  logic signed [4:0] ln_exp [spr_pkg::NLINE];
  logic ln_ovf [spr_pkg::NLINE];

  assign ion1 = flt_q[PB];
  assign ion2 = flt_q[PB+1];
  assign up_s = flt_q[PB+2];
  assign dn_s = flt_q[PB+3];
  assign thumb_s = flt_q[PB+6:PB+4];

  // display lines as two-digit value, exponent and overflow
  for (genvar l = 0; l < spr_pkg::NLINE; l++) begin : g_line
    localparam int B = l * spr_pkg::LINE_W;
    assign ln_val[l] = 7'(flt_q[B+7:B+4]) * 7'h0A + 7'(flt_q[B+3:B]);
    assign ln_exp[l] = $signed(flt_q[B+12:B+8]);
    assign ln_ovf[l] = flt_q[B+13];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [5:0] pol_q;
  logic [3:0] asn_q;
  logic [11:0] ovr_q;
  logic [3:0] sp_mant_q [spr_pkg::NCH];
  logic signed [4:0] sp_exp_q [spr_pkg::NCH];
  logic [5:0] relay_q;
  spr_pkg::spr_ui_t ui_q;
  logic [2:0] sel_q;
  logic fast_q;
  logic btn_prev_q;
  logic [spr_pkg::CNT_W-1:0] tmr_q;

  // ----------------------------------------------------------------
  // apb slave decode
  // ----------------------------------------------------------------
  logic hit_pol;
  logic hit_asn;
  logic hit_ovr;
  logic hit_stat;
  logic hit_sp;
  logic mapped;
  logic setup_ph;
  logic wr_en;
  logic [2:0] bus_idx;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;

  assign hit_pol = (paddr == spr_pkg::ADDR_POL);
  assign hit_asn = (paddr == spr_pkg::ADDR_ASN);
  assign hit_ovr = (paddr == spr_pkg::ADDR_OVR);
  assign hit_stat = (paddr == spr_pkg::ADDR_STAT);
  assign hit_sp = (paddr >= spr_pkg::ADDR_SP0) && (paddr <= spr_pkg::ADDR_SP5) &&
                  (paddr[1:0] == 2'h0);
  assign mapped = hit_pol | hit_asn | hit_ovr | hit_stat | hit_sp;
  assign setup_ph = psel & ~penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite & mapped;
  assign bus_idx = sp_index(paddr);
  assign stat_word = {20'h00000, sel_q, ui_q != spr_pkg::ST_IDLE, ion2, ion1, relay_q};
  assign rd_mux = hit_pol ? {26'h0000000, pol_q} :
                  hit_asn ? {28'h0000000, asn_q} :
                  hit_ovr ? {20'h00000, ovr_q} :
                  hit_stat ? stat_word :
                  hit_sp ? {23'h000000, sp_exp_q[bus_idx], sp_mant_q[bus_idx]} :
                  32'h00000000;

  // answer one cycle after setup; read data captured with it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~mapped;
      prdata <= setup_ph ? rd_mux : 32'h00000000;
    end
  end

  // control registers written by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pol_q <= spr_pkg::POL_RST;
      asn_q <= spr_pkg::ASN_RST;
      ovr_q <= spr_pkg::OVR_RST;
    end else if (wr_en) begin
      if (hit_pol) pol_q <= pwdata[5:0];
      if (hit_asn) asn_q <= pwdata[3:0];
      if (hit_ovr) ovr_q <= pwdata[11:0];
    end
  end

  // ----------------------------------------------------------------
  // setpoint buttons: select, scroll, display hold
  // ----------------------------------------------------------------
  logic held;
  logic press;
  logic thumb_ok;
  logic [2:0] thumb_idx;
  logic [spr_pkg::CNT_W-1:0] step_end;
  logic step_now;
  logic show_end;
  logic [9:0] step_res;

  assign held = up_s | dn_s;
  assign press = held & ~btn_prev_q;
  assign thumb_ok = (thumb_s != 3'h0) && (thumb_s != 3'h7);
  assign thumb_idx = thumb_s - 3'h1;
  assign step_end = fast_q ? spr_pkg::CNT_W'(FAST_CYC - 1) : spr_pkg::CNT_W'(SLOW_CYC - 1);
  assign step_now = (ui_q == spr_pkg::ST_HELD) && held && (tmr_q == step_end);
  assign show_end = (ui_q == spr_pkg::ST_SHOW) && !press &&
                    (tmr_q == spr_pkg::CNT_W'(SHOW_CYC - 1));
  assign step_res = step_sp(up_s, sp_mant_q[sel_q], sp_exp_q[sel_q]);

  // button state machine and its timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ui_q <= spr_pkg::ST_IDLE;
      sel_q <= 3'h0;
      fast_q <= 1'b0;
      btn_prev_q <= 1'b0;
      tmr_q <= '0;
    end else begin
      btn_prev_q <= held;
      unique case (ui_q)
        spr_pkg::ST_IDLE: begin
          tmr_q <= '0;
          fast_q <= 1'b0;
          if (press && thumb_ok) begin
            ui_q <= spr_pkg::ST_HELD;
            sel_q <= thumb_idx;
          end
        end
        spr_pkg::ST_HELD: begin
          if (!held) begin
            ui_q <= spr_pkg::ST_SHOW;
            tmr_q <= '0;
          end else if (step_now) begin
            tmr_q <= '0;
            if (step_res[9]) fast_q <= 1'b1;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
        spr_pkg::ST_SHOW: begin
          if (press) begin
            ui_q <= spr_pkg::ST_HELD;  // re-press keeps channel
            fast_q <= 1'b0;
            tmr_q <= '0;
          end else if (show_end) begin
            ui_q <= spr_pkg::ST_IDLE;
          end else begin
            tmr_q <= tmr_q + 1'b1;
          end
        end
      endcase
    end
  end

  // setpoint storage: scroll steps win over a bus write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < spr_pkg::NCH; i++) begin
        sp_mant_q[i] <= spr_pkg::MANT_ZERO;
        sp_exp_q[i] <= spr_pkg::EXP_MIN;
      end
    end else if (step_now) begin
      sp_mant_q[sel_q] <= step_res[8:5];
      sp_exp_q[sel_q] <= step_res[4:0];
    end else if (wr_en && hit_sp) begin
      sp_mant_q[bus_idx] <= pwdata[3:0];
      sp_exp_q[bus_idx] <= pwdata[8:4];
    end
  end

  // setpoint display and non-volatile store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_show_line <= 3'h0;
      sp_show_mant <= 4'h0;
      sp_show_exp <= 5'h00;
      nv_wr_stb <= 1'b0;
      nv_wr_chan <= 3'h0;
      nv_wr_mant <= 4'h0;
      nv_wr_exp <= 5'h00;
    end else begin
      sp_show_line <= (ui_q == spr_pkg::ST_IDLE || show_end) ? 3'h0 :
                      3'h1 << (sel_q >> 1);
      sp_show_mant <= sp_mant_q[sel_q];
      sp_show_exp <= sp_exp_q[sel_q];
      nv_wr_stb <= show_end;
      if (show_end) begin
        nv_wr_chan <= sel_q;
        nv_wr_mant <= sp_mant_q[sel_q];
        nv_wr_exp <= sp_exp_q[sel_q];
      end
    end
  end

  // ----------------------------------------------------------------
  // channel comparison and relay drive
  // ----------------------------------------------------------------
  logic upd;
  logic [5:0] below;
  logic [5:0] relay_d;

  // display data is frozen while a setpoint occupies the display
  assign upd = (ui_q == spr_pkg::ST_IDLE);

  for (genvar c = 0; c < spr_pkg::NCH; c++) begin : g_chan
    localparam int L = c / 2;
    logic ion_ok;
    logic auto_on;
    logic [1:0] ovr;

    spr_cmp_chan u_cmp (
      .clk(clk),
      .rst_n(rst_n),
      .upd(upd),
      .p_val(ln_val[L]),
      .p_exp(ln_exp[L]),
      .p_ovf(ln_ovf[L]),
      .sp_mant(sp_mant_q[c]),
      .sp_exp(sp_exp_q[c]),
      .below_q(below[c])
    );

    if (c < 2) begin : g_ion
      // an inhibit bit set means that gauge forces the relay off
      assign ion_ok = ((ion1 & ~asn_q[2*c]) | (ion2 & ~asn_q[2*c+1])) &
                      ~((ion1 & asn_q[2*c]) | (ion2 & asn_q[2*c+1]));
    end else begin : g_noion
      assign ion_ok = 1'b1;
    end

    assign auto_on = ion_ok & (pol_q[c] ? ~below[c] : below[c]);
    assign ovr = ovr_q[2*c+1:2*c];
    assign relay_d[c] = (ovr == spr_pkg::OVR_ON) ? 1'b1 :
                        (ovr == spr_pkg::OVR_OFF) ? 1'b0 :
                        auto_on;
  end

  // relay contacts and their indicators
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      relay_q <= 6'h00;
      relay <= 6'h00;
      relay_led <= 6'h00;
    end else begin
      relay_q <= relay_d;
      relay <= relay_d;
      relay_led <= relay_d;
    end
  end

endmodule : spr_relay_ctrl

/* File: spr_relay_ctrl_assertions.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checks of the relay controller
// ------------------------------------------------------------
module spr_relay_ctrl_assertions #(
  parameter int SHOW_CYC = 200  // setpoint display hold
) (
  input wire logic clk,                // clock
  input wire logic rst_n,              // reset, active low
  input wire logic psel,               // apb select
  input wire logic penable,            // apb enable
  input wire logic pready,             // apb ready
  input wire logic pslverr,            // apb error
  input wire logic btn_up,             // up button
  input wire logic btn_down,           // down button
  input wire logic [2:0] thumbwheel,   // channel select
  input wire logic [5:0] relay,        // relay drive
  input wire logic [5:0] relay_led,    // status indicators
  input wire logic [2:0] sp_show_line, // line taken by setpoint
  input wire logic nv_wr_stb,          // store pulse
  input wire logic [2:0] nv_wr_chan    // stored channel
);
  logic [31:0] idle_q;  // cycles shown with no button pressed
  // count display cycles after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) idle_q <= 32'h0;
    else if (btn_up || btn_down || sp_show_line == 3'h0) idle_q <= 32'h0;
    else idle_q <= idle_q + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  led_match_a: assert property (relay_led == relay)
    else $error("indicators differ from relays");
  line_onehot_a: assert property ($onehot0(sp_show_line))
    else $error("more than one display line taken");
  show_start_a: assert property ((btn_up || btn_down) && thumbwheel inside {[3'h1:3'h6]}
    && sp_show_line == 3'h0 |-> ##[1:8] sp_show_line != 3'h0)
    else $error("press did not show the setpoint");
  show_hold_a: assert property ((btn_up || btn_down) && sp_show_line != 3'h0
    |=> sp_show_line != 3'h0) else $error("display released while held");
  show_len_a: assert property ($fell(|sp_show_line)
    |-> idle_q >= SHOW_CYC && idle_q <= SHOW_CYC + 8) else $error("display hold time wrong");
  store_line_a: assert property (nv_wr_stb |-> sp_show_line == 3'h0
    && $past(sp_show_line) == (nv_wr_chan < 3'h2 ? 3'h1 : nv_wr_chan < 3'h4 ? 3'h2 : 3'h4))
    else $error("store not at display release");
  store_pulse_a: assert property (nv_wr_stb |=> !nv_wr_stb)
    else $error("store pulse too long");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single pulse in first access cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : spr_relay_ctrl_assertions

/* File: spr_equip_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// process equipment on the relay contacts
// ------------------------------------------------------------
module spr_equip_model (
  input wire logic clk,          // clock
  input wire logic rst_n,        // reset, active low
  input wire logic [5:0] relay,  // coil drive
  output logic [5:0] contact_q   // closed contacts
);
  // contacts follow the coils one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) contact_q <= 6'h00;
    else contact_q <= relay;
  end
endmodule : spr_equip_model

/* File: tb_setpoint_relay_controller.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
// ------------------------------------------------------------
// bench of the relay controller
// ------------------------------------------------------------
module tb_setpoint_relay_controller;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, nv_wr_stb, btn_up = 1'b0, btn_down = 1'b0;
  logic ion_gauge_one_on = 1'b0, ion_gauge_two_on = 1'b0;
  logic [2:0] thumbwheel = 3'h0, sp_show_line, nv_wr_chan;
  logic [13:0] ln1 = 14'h1A10, ln2 = 14'h1D50, ln3 = 14'h0599;
  logic [5:0] relay, relay_led, contact;
  logic [3:0] nv_wr_mant, sp_show_mant;
  logic [4:0] nv_wr_exp, sp_show_exp;
  logic [13:0] pv[6] = '{14'h1D49, 14'h1D52, 14'h1D55, 14'h1D50, 14'h1C99, 14'h2999};
  logic ex[6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int n_fail = 0, check_count = 0;
  // clock of 100 ns
  always #50 clk = ~clk;
  spr_relay_ctrl #(.SHOW_CYC(200), .SLOW_CYC(20), .FAST_CYC(5)) DUT (.clk(clk), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line1_ovf(ln1[13]),
    .line1_exp(ln1[12:8]), .line1_digit_hi(ln1[7:4]), .line1_digit_lo(ln1[3:0]),
    .line2_ovf(ln2[13]), .line2_exp(ln2[12:8]), .line2_digit_hi(ln2[7:4]),
    .line2_digit_lo(ln2[3:0]), .line3_ovf(ln3[13]), .line3_exp(ln3[12:8]),
    .line3_digit_hi(ln3[7:4]), .line3_digit_lo(ln3[3:0]), .ion_gauge_one_on(ion_gauge_one_on),
    .ion_gauge_two_on(ion_gauge_two_on), .btn_up(btn_up), .btn_down(btn_down),
    .thumbwheel(thumbwheel), .relay(relay), .relay_led(relay_led), .sp_show_line(sp_show_line),
    .sp_show_mant(sp_show_mant), .sp_show_exp(sp_show_exp), .nv_wr_stb(nv_wr_stb),
    .nv_wr_chan(nv_wr_chan),
    .nv_wr_mant(nv_wr_mant), .nv_wr_exp(nv_wr_exp));
  spr_equip_model EQ (.clk(clk), .rst_n(rst_n), .relay(relay), .contact_q(contact));
  // one apb transfer, then let pins and relays settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : apb
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask : settle
  task automatic t_regs();
    apb(0, 8'h00, 0); `CHK(rd, 32'h0)
    apb(0, 8'h04, 0); `CHK(rd, 32'h0)
    apb(0, 8'h08, 0); `CHK(rd, 32'h0)
    apb(0, 8'h10, 0); `CHK(rd, 32'h140)
    apb(0, 8'h40, 0); `CHK(err, 1'b1)
  endtask : t_regs
  task automatic t_zero();
    `CHK({relay[2], contact[2]}, 2'b00)
    apb(1, 8'h00, 32'h04); `CHK({relay[2], contact[2]}, 2'b11)
    apb(1, 8'h00, 32'h00);
  endtask : t_zero
  task automatic t_hyst();
    apb(1, 8'h18, 32'h1D5);
    for (int i = 0; i < 6; i++) begin
      ln2 <= pv[i];
      settle();
      `CHK(relay[2], ex[i])
    end
    ln2 <= 14'h1E10;
    settle();
    `CHK(relay[2], 1'b0)
    apb(1, 8'h00, 32'h04); `CHK(relay[2], 1'b1)
    apb(1, 8'h00, 32'h00);
  endtask : t_hyst
  task automatic t_atm();
    apb(1, 8'h20, 32'h0F); `CHK(relay[4], 1'b1)
    ln3 <= 14'h2999;
    settle();
    `CHK(relay[5:4], 2'b00)
  endtask : t_atm
  task automatic t_ion();
    apb(1, 8'h10, 32'h0F); `CHK(relay[0], 1'b0)
    ion_gauge_one_on <= 1'b1;
    settle();
    `CHK(relay[0], 1'b1)
    apb(1, 8'h04, 32'h01); `CHK(relay[0], 1'b0)
    apb(1, 8'h04, 32'h02); `CHK(relay[0], 1'b1)
    ion_gauge_one_on <= 1'b0;
    apb(1, 8'h00, 32'h01); `CHK(relay[0], 1'b0)
  endtask : t_ion
  task automatic t_ovr();
    apb(1, 8'h08, 32'h020); `CHK(relay[2], 1'b1)
    apb(1, 8'h08, 32'h010); `CHK(relay[2], 1'b0)
    ln2 <= 14'h1D49;
    apb(1, 8'h08, 32'h030); `CHK(relay[2], 1'b1)
  endtask : t_ovr
  task automatic t_btn();
    thumbwheel <= 3'h3;
    btn_up <= 1'b1;
    repeat (12) @(posedge clk);
    `CHK({sp_show_line, sp_show_mant, sp_show_exp}, {3'h2, 4'h5, 5'h1D})
    repeat (18) @(posedge clk);
    btn_up <= 1'b0;
    while (nv_wr_stb !== 1'b1) @(posedge clk);
    `CHK({nv_wr_chan, nv_wr_mant, nv_wr_exp}, {3'h2, 4'h6, 5'h1D})
    apb(0, 8'h18, 0); `CHK(rd, 32'h1D6)
    // hold down across a decade: five slow steps, the crossing, then two fast ones
    btn_down <= 1'b1;
    repeat (132) @(posedge clk);
    btn_down <= 1'b0;
    while (nv_wr_stb !== 1'b1) @(posedge clk);
    `CHK({nv_wr_chan, nv_wr_mant, nv_wr_exp}, {3'h2, 4'h7, 5'h1C})
  endtask : t_btn
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_zero();
    t_hyst();
    t_atm();
    t_ion();
    t_ovr();
    t_btn();
    test_done();
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule : tb_setpoint_relay_controller
bind spr_relay_ctrl spr_relay_ctrl_assertions #(.SHOW_CYC(SHOW_CYC)) u_chk (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .btn_up(btn_up), .btn_down(btn_down), .thumbwheel(thumbwheel), .relay(relay),
  .relay_led(relay_led), .sp_show_line(sp_show_line), .nv_wr_stb(nv_wr_stb),
  .nv_wr_chan(nv_wr_chan));
